// >>> hbfs_core.sv
// H-bridge protection and mode supervisor: current limit, stall fault,
// latched overcurrent, thermal and supply lockout, sleep and soft start.
// Assumes all inputs are synchronous to MCLK; analog comparators outside.
`timescale 1ns/1ps
`include "hbfs_regs.svh"

// Notes on behaviour
// - Sense above threshold 3 us cuts duty
// - Limit persisting 275 ms raises fault
// - Limit fault keeps bridge running, limited
// - Limit fault clears itself when load frees
// - Qualified clamp disables bridge, flags fault
// - Overcurrent shutdown latched until reset or power cycle
// - High and low side sensed separately
// - Overcurrent independent of current limit
// - Overheat disables bridge, circuits keep running
// - Overheat recovery after hysteresis, automatic
// - Undervoltage disables all, flags, resets logic
// - Leaving undervoltage restarts operation
// - Either control high means active
// - Both controls low means sleep, Hi-Z
// - Any shutdown fault keeps bridge disabled
// - Sleep clears the limit fault
// - Sleep exit pulses fault low briefly
// - Drive entry ramps duty from zero, 12 ms
module hbfs_core #(
	parameter int ILIM_FLT_CYC = `HBFS_ILIM_FLT_CYC,
	parameter int RAMP_CYC     = `HBFS_RAMP_CYC,
	parameter int OCP_CYC      = `HBFS_OCP_CYC,
	parameter int PULSE_CYC    = `HBFS_WAKE_PULSE_CYC
) (
	input  wire logic                    MCLK,             // 40 MHz clock
	input  wire logic                    RST_B,            // Sync reset, active low
	input  wire logic                    DRIVE_CTRL_A,     // Drive control input A
	input  wire logic                    DRIVE_CTRL_B,     // Drive control input B
	input  wire logic                    SENSE_OVER,       // Sense above limit threshold
	input  wire logic                    HS_CLAMP,         // High-side clamp active
	input  wire logic                    LS_CLAMP,         // Low-side clamp active
	input  wire logic                    TEMP_HOT,         // Over-temperature, with hysteresis
	input  wire logic                    SUPPLY_LOW,       // Supply below lockout
	output logic                         ERROR_FLAG_LOW_O, // Fault pin output value
	output logic                         ERROR_FLAG_LOW_OE,// Fault pin drive enable
	output logic                         BRIDGE_EN,        // Bridge transistors enabled
	output logic [1:0]                   DRIVE_STATE,      // Output drive pattern
	output logic [`HBFS_DUTY_W-1:0]      DUTY_CEIL,        // Allowed PWM duty ceiling
	output logic                         LIMIT_ACTIVE,     // Current limit cutting duty
	output logic                         CIRCUITS_ON       // Internal circuits powered
);
	localparam int DW = `HBFS_DUTY_W;
	localparam int RW = $clog2(RAMP_CYC + 1);
	localparam int PW = $clog2(PULSE_CYC + 1);
	localparam logic [RW-1:0] RAMP_STEP = RW'(RAMP_CYC / 255);

	hbfs_pkg::hbfs_mode_t  mode_r, mode_nxt;
	hbfs_pkg::hbfs_drive_t drv_prev_r;
	logic                  ocp_latch_r;
	logic [DW-1:0]         duty_r;
	logic [RW-1:0]         ramp_cnt_r;
	logic [PW-1:0]         pulse_cnt_r;
	logic                  ilim_q, stall_q, hs_q, ls_q;

	// Logic reset comes from the core reset and from lockout alike
	wire rst_int_b = RST_B && !SUPPLY_LOW;
	wire [1:0] drv_req = {DRIVE_CTRL_A, DRIVE_CTRL_B};
	wire want_active = DRIVE_CTRL_A || DRIVE_CTRL_B;
	wire in_sleep = !want_active;
	wire ocp_trip = hs_q || ls_q;
	wire shut_fault = ocp_latch_r || TEMP_HOT;
	wire waking = (mode_r == hbfs_pkg::HBFS_SLEEP) && want_active;
	wire drive_entry = (drv_req == 2'b10 || drv_req == 2'b01) &&
		(drv_prev_r == hbfs_pkg::HBFS_DRV_COAST || drv_prev_r == hbfs_pkg::HBFS_DRV_BRAKE);
	wire ramp_tick = (ramp_cnt_r >= RAMP_STEP);

	hbfs_persist #(.COUNT(`HBFS_ILIM_DEGL_CYC)) u_degl (
		.clk  (MCLK),
		.rst_b(rst_int_b),
		.clr  (in_sleep),
		.cond (SENSE_OVER),
		.hit  (ilim_q)
	);

	hbfs_persist #(.COUNT(ILIM_FLT_CYC)) u_stall (
		.clk  (MCLK),
		.rst_b(rst_int_b),
		.clr  (in_sleep),
		.cond (ilim_q),
		.hit  (stall_q)
	);

	hbfs_persist #(.COUNT(OCP_CYC)) u_ocp_hs (
		.clk  (MCLK),
		.rst_b(rst_int_b),
		.clr  (1'b0),
		.cond (HS_CLAMP),
		.hit  (hs_q)
	);

	hbfs_persist #(.COUNT(OCP_CYC)) u_ocp_ls (
		.clk  (MCLK),
		.rst_b(rst_int_b),
		.clr  (1'b0),
		.cond (LS_CLAMP),
		.hit  (ls_q)
	);

	always_comb begin
		mode_nxt = mode_r;
		unique case (mode_r)
			// Waking into a standing fault goes straight to shutdown, no bridge glitch
			hbfs_pkg::HBFS_SLEEP: begin
				if (want_active)
					mode_nxt = (shut_fault || ocp_trip) ? hbfs_pkg::HBFS_SHUT
						: hbfs_pkg::HBFS_ACTIVE;
			end
			hbfs_pkg::HBFS_ACTIVE: begin
				if (shut_fault || ocp_trip)
					mode_nxt = hbfs_pkg::HBFS_SHUT;
				else if (in_sleep)
					mode_nxt = hbfs_pkg::HBFS_SLEEP;
			end
			hbfs_pkg::HBFS_SHUT: begin
				if (!shut_fault && !ocp_trip)
					mode_nxt = want_active ? hbfs_pkg::HBFS_ACTIVE : hbfs_pkg::HBFS_SLEEP;
			end
			default: mode_nxt = hbfs_pkg::HBFS_SLEEP;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (!rst_int_b) begin
			mode_r      <= hbfs_pkg::HBFS_SLEEP;
			drv_prev_r  <= hbfs_pkg::HBFS_DRV_COAST;
			ocp_latch_r <= 1'b0;
		end else begin
			mode_r     <= mode_nxt;
			drv_prev_r <= hbfs_pkg::hbfs_drive_t'(drv_req);
			if (ocp_trip)
				ocp_latch_r <= 1'b1;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!rst_int_b || in_sleep || drive_entry) begin
			duty_r     <= '0;
			ramp_cnt_r <= '0;
		end else if (ilim_q) begin
			duty_r     <= (duty_r == '0) ? '0 : duty_r - DW'(1);
			ramp_cnt_r <= '0;
		end else if (ramp_tick) begin
			ramp_cnt_r <= '0;
			if (duty_r != `HBFS_DUTY_FULL)
				duty_r <= duty_r + DW'(1);
		end else begin
			ramp_cnt_r <= ramp_cnt_r + RW'(1);
		end
	end

	always_ff @(posedge MCLK) begin
		if (!rst_int_b)
			pulse_cnt_r <= '0;
		else if (waking)
			pulse_cnt_r <= PW'(PULSE_CYC);
		else if (pulse_cnt_r != '0)
			pulse_cnt_r <= pulse_cnt_r - PW'(1);
	end

	wire bridge_ok = (mode_nxt == hbfs_pkg::HBFS_ACTIVE) && rst_int_b;
	wire flag_nxt = !rst_int_b || ocp_latch_r || ocp_trip || TEMP_HOT ||
		(stall_q && want_active) || waking || (pulse_cnt_r > PW'(1));

	// Outputs registered; reset value shows lockout fault
	always_ff @(posedge MCLK) begin
		ERROR_FLAG_LOW_O  <= 1'b0;
		ERROR_FLAG_LOW_OE <= flag_nxt;
		BRIDGE_EN         <= bridge_ok;
		DRIVE_STATE       <= bridge_ok ? drv_req : 2'b00;
		DUTY_CEIL         <= bridge_ok ? duty_r : '0;
		LIMIT_ACTIVE      <= bridge_ok && ilim_q;
		CIRCUITS_ON       <= rst_int_b && want_active;
	end
endmodule

// >>> hbfs_core_chk.sv
// Port checker for hbfs_core, attached to every instance by bind.
// Assumes one clock; input run lengths are counted here.
`timescale 1ns/1ps
`include "hbfs_regs.svh"
module hbfs_core_chk #(
	parameter int ILIM_FLT_CYC = 200,
	parameter int OCP_CYC      = 40
) (
	input wire logic MCLK, RST_B, SUPPLY_LOW, TEMP_HOT, // Clock, reset, faults
	input wire logic DRIVE_CTRL_A, DRIVE_CTRL_B,        // Controls
	input wire logic SENSE_OVER, HS_CLAMP, LS_CLAMP,    // Sense inputs
	input wire logic ERROR_FLAG_LOW_OE, BRIDGE_EN,      // Fault, bridge
	input wire logic LIMIT_ACTIVE, CIRCUITS_ON,         // Status
	input wire logic [`HBFS_DUTY_W-1:0] DUTY_CEIL       // Duty ceiling
);
	logic        slp, calm, ocp_r;
	logic [7:0]  clamp_r;
	logic [15:0] sense_r;
	assign slp  = !DRIVE_CTRL_A && !DRIVE_CTRL_B;
	assign calm = !TEMP_HOT && !HS_CLAMP && !LS_CLAMP && !ocp_r && !SUPPLY_LOW;
	// Saturate so a long stall never wraps back to a trip value
	always_ff @(posedge MCLK) begin
		clamp_r <= (HS_CLAMP || LS_CLAMP) ? clamp_r + {7'h00, clamp_r != 8'hff} : 8'h00;
		sense_r <= (SENSE_OVER && !slp) ? sense_r + {15'h0000, sense_r != 16'hffff} : 16'h0000;
		ocp_r   <= RST_B && !SUPPLY_LOW && (ocp_r || clamp_r == OCP_CYC + 3);
	end
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_B);
	sequence s_wake;
		slp ##1 !slp && calm;
	endsequence
	sequence s_rest;
		slp && calm ##1 slp && calm;
	endsequence
	sequence s_run;
		!slp && calm ##1 !slp && calm;
	endsequence
	a_sleep_off: assert property (slp |=> !BRIDGE_EN)
		else $error("bridge on in sleep");
	a_wake_pulse: assert property (s_wake |=> ERROR_FLAG_LOW_OE && BRIDGE_EN && DUTY_CEIL < 8'h02)
		else $error("no wake pulse or ramp");
	a_sleep_clear: assert property (s_rest |=> !ERROR_FLAG_LOW_OE)
		else $error("fault shown in sleep");
	a_run_on: assert property (s_run |=> BRIDGE_EN)
		else $error("bridge off while active");
	a_hot_off: assert property (TEMP_HOT && !slp && !SUPPLY_LOW |=> !BRIDGE_EN && ERROR_FLAG_LOW_OE && CIRCUITS_ON)
		else $error("hot not handled");
	a_low_reset: assert property (SUPPLY_LOW |=> !BRIDGE_EN && !CIRCUITS_ON && ERROR_FLAG_LOW_OE)
		else $error("lockout not handled");
	a_ocp_trip: assert property (clamp_r == OCP_CYC + 3 |-> !BRIDGE_EN && ERROR_FLAG_LOW_OE)
		else $error("clamp did not trip");
	a_ocp_hold: assert property (ocp_r |-> !BRIDGE_EN && ERROR_FLAG_LOW_OE)
		else $error("overcurrent not latched");
	a_limit_cut: assert property (sense_r == 16'h007d && calm |-> LIMIT_ACTIVE)
		else $error("limit not active");
	a_stall_flag: assert property (sense_r == ILIM_FLT_CYC + 130 && calm |-> ERROR_FLAG_LOW_OE && BRIDGE_EN)
		else $error("stall not flagged");
endmodule
bind hbfs_core hbfs_core_chk #(.ILIM_FLT_CYC(ILIM_FLT_CYC), .OCP_CYC(OCP_CYC)) u_hbfs_core_chk (.*);

// >>> hbfs_core_test.sv
// Self-checking bench for hbfs_core with shortened timers.
// Assumes inputs change at the falling edge; host model reads the pin.
`timescale 1ns/1ps
`include "hbfs_regs.svh"
module hbfs_core_test;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic ca = 1'b0, cb = 1'b0, sense = 1'b0, hs = 1'b0, ls = 1'b0, hot = 1'b0, low = 1'b0;
	logic fo, foe, br, lim, con, pin;
	logic [1:0] st;
	logic [`HBFS_DUTY_W-1:0] duty;
	int errors = 0;
	int n_compared = 0;
	int ticks = 0;
	always #12.5 mclk = ~mclk;
	hbfs_core #(.ILIM_FLT_CYC(200), .RAMP_CYC(2550)) u_hbfs_core (
		.MCLK(mclk), .RST_B(rst_b), .DRIVE_CTRL_A(ca), .DRIVE_CTRL_B(cb),
		.SENSE_OVER(sense), .HS_CLAMP(hs), .LS_CLAMP(ls), .TEMP_HOT(hot),
		.SUPPLY_LOW(low), .ERROR_FLAG_LOW_O(fo), .ERROR_FLAG_LOW_OE(foe),
		.BRIDGE_EN(br), .DRIVE_STATE(st), .DUTY_CEIL(duty), .LIMIT_ACTIVE(lim),
		.CIRCUITS_ON(con));
	hbfs_host u_hbfs_host (.OE(foe), .O(fo), .LEVEL(pin));
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic t_wake;
		ca = 1'b1;
		cyc(2);
		chk(8'({pin, st}), 8'h02);
		cyc(100);
		chk(8'({pin, duty > 8'h07 && duty < 8'h0d}), 8'h03);
		cb = 1'b1;
		cyc(2);
		chk(8'(st), 8'h03);
		ca = 1'b0;
		cb = 1'b0;
		cyc(2);
		chk(8'({br, con}), 8'h00);
	endtask
	task automatic t_limit;
		ca = 1'b1;
		sense = 1'b1;
		cyc(100);
		chk(8'(lim), 8'h00);
		cyc(30);
		chk(8'({lim, pin}), 8'h03);
		cyc(210);
		chk(8'({br, pin}), 8'h02);
		chk(duty, 8'h00);
		sense = 1'b0;
		cyc(5);
		chk(8'(pin), 8'h01);
	endtask
	task automatic t_fault;
		hot = 1'b1;
		cyc(2);
		chk(8'({br, pin, con}), 8'h01);
		hot = 1'b0;
		low = 1'b1;
		cyc(2);
		chk(8'({br, pin, con}), 8'h00);
		low = 1'b0;
		cyc(3);
		chk(8'({br, con}), 8'h03);
	endtask
	task automatic t_ocp(input logic side);
		hs = !side;
		ls = side;
		cyc(50);
		chk(8'({br, pin, lim}), 8'h00);
		hs = 1'b0;
		ls = 1'b0;
		ca = 1'b0;
		cyc(3);
		ca = 1'b1;
		cyc(3);
		chk(8'({br, pin}), 8'h00);
		rst_b = 1'b0;
		cyc(1);
		rst_b = 1'b1;
		cyc(3);
		chk(8'(br), 8'h01);
	endtask
	initial begin
		cyc(6);
		rst_b = 1'b1;
		cyc(2);
		t_wake();
		t_limit();
		t_fault();
		t_ocp(1'b0);
		t_ocp(1'b1);
		give_verdict();
	end
	always @(posedge mclk) begin
		ticks++;
		if (ticks == 3000) begin
			errors++;
			give_verdict();
		end
	end
endmodule

// >>> hbfs_host.sv
// Host side of the fault line: a pull-up on the open-drain pin.
// Assumes the device only ever pulls the pin low.
`timescale 1ns/1ps
module hbfs_host (
	input  wire logic OE,    // Device pulls pin
	input  wire logic O,     // Value while pulled
	output wire logic LEVEL  // Level seen by host
);
	assign LEVEL = OE ? O : 1'b1;
endmodule

// >>> hbfs_persist.sv
// Persistence timer: output rises once the input has held high for a
// set number of consecutive cycles, and falls with the input.
// Assumes a synchronous active-low reset and a single clock.
`timescale 1ns/1ps
module hbfs_persist #(
	parameter int COUNT = 4
) (
	input  wire logic clk,    // Core clock
	input  wire logic rst_b,  // Synchronous reset, active low
	input  wire logic clr,    // Restart the count
	input  wire logic cond,   // Condition being qualified
	output logic      hit     // Condition has persisted
);
	localparam int W = $clog2(COUNT + 1);

	logic [W-1:0] cnt_r;
	logic         hit_nxt;
	wire          at_end = (cnt_r == W'(COUNT));

	assign hit_nxt = cond && !clr && (at_end || (cnt_r == W'(COUNT - 1)));

	always_ff @(posedge clk) begin
		if (!rst_b || clr || !cond) begin
			cnt_r <= '0;
			hit   <= 1'b0;
		end else begin
			if (!at_end)
				cnt_r <= cnt_r + W'(1);
			hit <= hit_nxt;
		end
	end
endmodule

// >>> hbfs_pkg.sv
// Types shared by the H-bridge fault supervisor files.
// Assumes nothing beyond a SystemVerilog tool.
package hbfs_pkg;
	typedef enum logic [1:0] {
		HBFS_SLEEP  = 2'b00,
		HBFS_ACTIVE = 2'b01,
		HBFS_SHUT   = 2'b11
	} hbfs_mode_t;

	typedef enum logic [1:0] {
		HBFS_DRV_COAST   = 2'b00,
		HBFS_DRV_REVERSE = 2'b01,
		HBFS_DRV_FORWARD = 2'b10,
		HBFS_DRV_BRAKE   = 2'b11
	} hbfs_drive_t;
endpackage

// >>> hbfs_regs.svh
// Timing constants and codes for the H-bridge fault supervisor.
// Assumes a 40 MHz core clock; counts derive from printed times.
`ifndef HBFS_REGS_SVH
`define HBFS_REGS_SVH

`define HBFS_CLK_KHZ        40000
`define HBFS_ILIM_DEGL_NS   3000
`define HBFS_ILIM_DEGL_CYC  ((`HBFS_ILIM_DEGL_NS * `HBFS_CLK_KHZ + 999999) / 1000000)
`define HBFS_ILIM_FLT_MS    275
`define HBFS_ILIM_FLT_CYC   (`HBFS_ILIM_FLT_MS * `HBFS_CLK_KHZ)
`define HBFS_RAMP_MS        12
`define HBFS_RAMP_CYC       (`HBFS_RAMP_MS * `HBFS_CLK_KHZ)
`define HBFS_OCP_CYC        40
`define HBFS_WAKE_PULSE_CYC 40
`define HBFS_DUTY_W         8
`define HBFS_DUTY_FULL      8'hff

`endif
